// ===== cra_pkg.sv
// cra_pkg: shared constants, register attribute masks and byte-lane helper
package cra_pkg;

  // ************************************************************
  // i/o space decode and configuration pointer layout
  // ************************************************************
  localparam int          AW          = 16;
  localparam int          IW          = 6;
  localparam int          NREG        = 6;
  localparam logic [15:0] PTR_IO      = 16'h0C00;
  localparam logic [15:0] DATA_IO     = 16'h0C04;
  localparam int          PTR_EN_BIT  = 31;
  localparam int          PTR_IDX_LSB = 2;
  localparam logic [31:0] PTR_DEF     = 32'h8000_00FC;
  localparam logic [3:0]  BE_DWORD    = 4'hF;
  localparam logic [31:0] ALL_ONES    = 32'hFFFF_FFFF;

  // ************************************************************
  // configuration register indices
  // ************************************************************
  localparam logic [IW-1:0] IDX_ID   = 6'h00;
  localparam logic [IW-1:0] IDX_CTL  = 6'h01;
  localparam logic [IW-1:0] IDX_STS  = 6'h02;
  localparam logic [IW-1:0] IDX_SET  = 6'h03;
  localparam logic [IW-1:0] IDX_DBL  = 6'h04;
  localparam logic [IW-1:0] IDX_ONCE = 6'h05;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int CTL_LOCK_BIT = 16;
  localparam int STS_PME_LSB  = 0;
  localparam int STS_ENA_LSB  = 4;
  localparam int STS_RO_LSB   = 24;
  localparam int NPORT        = 4;

  // ************************************************************
  // per-register attribute masks, register 0 in the low word
  // ************************************************************
  typedef logic [NREG-1:0][31:0] cra_mask_t;
  localparam cra_mask_t RW_MASK   = {ALL_ONES, 32'h0000_0000, 32'h0000_0000,
                                     32'h0000_00F0, 32'h0001_FFFF, 32'h0000_0000};
  localparam cra_mask_t LOCK_MASK = {32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
                                     32'h0000_0000, 32'h0000_FF00, 32'h0000_0000};
  localparam cra_mask_t ONCE_MASK = {ALL_ONES, 32'h0000_0000, 32'h0000_0000,
                                     32'h0000_0000, 32'h0001_0000, 32'h0000_0000};
  localparam cra_mask_t W1C_MASK  = {32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
                                     32'h0000_000F, 32'h0000_0000, 32'h0000_0000};
  localparam cra_mask_t W1S_MASK  = {32'h0000_0000, 32'h0000_0000, 32'h0000_00FF,
                                     32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
  localparam cra_mask_t WO_MASK   = {32'h0000_0000, ALL_ONES, 32'h0000_0000,
                                     32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
  localparam cra_mask_t DEF_MASK  = {ALL_ONES, ALL_ONES, 32'h0000_00FF,
                                     32'hFF00_00FF, 32'h0001_FFFF, ALL_ONES};

  // byte enable to bit mask, lane n covers bits 8n+7..8n
  function automatic logic [31:0] cra_be_mask(input logic [3:0] be);
    logic [31:0] m;
    m = '0;
    for (int n = 0; n < 4; n++) begin
      m[8*n +: 8] = {8{be[n]}};
    end
    return m;
  endfunction : cra_be_mask

endpackage : cra_pkg

// ===== cra_if.sv
// cra_if: host i/o bus and open-drain event pin joining the two ends
`timescale 1ns/100ps
interface cra_if;
  import cra_pkg::*;
  logic          req;
  logic          we;
  logic [AW-1:0] addr;
  logic [3:0]    be;
  logic [31:0]   wdata;
  logic [31:0]   rdata;
  logic          ack;
  logic          pme_o;
  logic          pme_oe;
  wire           pm_event_request_n;

  // open-drain wire, pulled high when nobody drives
  assign pm_event_request_n = pme_oe ? pme_o : 1'b1;

  modport dev  (input req, we, addr, be, wdata, output rdata, ack, pme_o, pme_oe);
  modport host (output req, we, addr, be, wdata, input rdata, ack, pm_event_request_n);
endinterface : cra_if

// ===== cra_attr_merge.sv
// cra_attr_merge: next value of one register word under its bit attributes
`timescale 1ns/100ps
module cra_attr_merge (
  // current value and write
  input  wire logic [31:0] cur,
  input  wire logic        wr_en,
  input  wire logic [3:0]  be,
  input  wire logic [31:0] wdata,
  // attributes of this word
  input  wire logic [31:0] rw_mask,
  input  wire logic [31:0] w1c_mask,
  input  wire logic [31:0] w1s_mask,
  input  wire logic [31:0] locked,
  // hardware updates
  input  wire logic [31:0] hw_set,
  input  wire logic [31:0] hw_clr,
  // result
  output logic      [31:0] nxt
);
  import cra_pkg::*;

  logic [31:0] lanes;
  logic [31:0] sw_rw;

  // only addressed byte lanes take part in a write
  assign lanes = wr_en ? cra_be_mask(be) : 32'h0000_0000;
  assign sw_rw = lanes & rw_mask & ~locked;

  // software terms first, hardware last so a set event beats a clear
  always_comb begin
    nxt = (cur & ~sw_rw) | (wdata & sw_rw);
    nxt = nxt & ~(lanes & wdata & w1c_mask);
    nxt = nxt | (lanes & wdata & w1s_mask);
    nxt = (nxt & ~hw_clr) | hw_set;
  end
endmodule : cra_attr_merge

// ===== cra_dev.sv
// cra_dev: device end, i/o decode, pointer, configuration words, event pin
// Overview of operation
// - byte, word, dword accesses touch addressed bytes
// - pointer register answers only dword accesses
// - lowest byte address holds lowest field bits
// - writes to read-only bits are ignored
// - write-only location fires action, reads meaningless
// - write-one-clear: hardware sets, software one clears
// - write-one-set: software one sets, hardware clears
// - lockable bits ignore writes once locked
// - write-once bits lock after first write
// - software masks reserved bits on reads
// - software read-merge-writes registers with reserved bits
// - pointer written directly, no merge needed
// - i/o control registers gate configuration access
// - open-drain event pin on port power requests
// - soft reset spares sticky, power reset clears all
`timescale 1ns/100ps
module cra_dev #(
  parameter logic [31:0] ID_VALUE = 32'h0001_0001 // arbitrary identity word
) (
  // clock and resets
  input  wire logic                        sys_clk,
  input  wire logic                        rst_b,
  input  wire logic                        soft_reset_in_n,
  // host side
  cra_if.dev                               bus,
  // hardware events
  input  wire logic [cra_pkg::NPORT-1:0]   port_pme_req,
  input  wire logic [7:0]                  hw_status,
  input  wire logic [7:0]                  set_bits_clr,
  input  wire logic                        hw_lock,
  // write-only action
  output logic                             doorbell_pulse,
  output logic      [31:0]                 doorbell_data
);
  import cra_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [NREG-1:0][31:0] cfg;
    logic [NREG-1:0][31:0] done;
    logic [31:0]           ptr;
    logic [31:0]           rdata;
    logic                  ack;
    logic [NPORT-1:0]      pme_s1;
    logic [NPORT-1:0]      pme_s2;
    logic                  pme_drive;
    logic                  dbl_pulse;
    logic [31:0]           dbl_data;
  } cra_dev_state_t;

  localparam cra_dev_state_t ST_RST = '{
    cfg       : {{(NREG-1)*32{1'b0}}, ID_VALUE},
    done      : '0,
    ptr       : '0,
    rdata     : '0,
    ack       : 1'b0,
    pme_s1    : '0,
    pme_s2    : '0,
    pme_drive : 1'b0,
    dbl_pulse : 1'b0,
    dbl_data  : '0
  };

  cra_dev_state_t st_reg;
  cra_dev_state_t st_next;
  logic [31:0]    sticky_reg;
  logic [31:0]    sticky_next;

  // ************************************************************
  // access decode
  // ************************************************************
  logic                  take;
  logic                  at_ptr;
  logic                  at_data;
  logic                  cfg_on;
  logic [IW-1:0]         idx;
  logic                  idx_ok;
  logic                  cfg_wr;
  logic                  lock_on;
  logic [NREG-1:0][31:0] cur;
  logic [NREG-1:0][31:0] hw_set;
  logic [NREG-1:0][31:0] hw_clr;
  logic [NREG-1:0][31:0] locked;
  logic [31:0]           merged;
  logic [31:0]           rd_word;

  // one request per handshake: the cycle after an answer is never taken twice
  assign take    = bus.req && !st_reg.ack;
  assign at_ptr  = ({bus.addr[AW-1:2], 2'b00} == PTR_IO);
  assign at_data = ({bus.addr[AW-1:2], 2'b00} == DATA_IO);
  assign cfg_on  = st_reg.ptr[PTR_EN_BIT];
  assign idx     = st_reg.ptr[PTR_IDX_LSB +: IW];
  assign idx_ok  = (idx < IW'(NREG));
  assign cfg_wr  = take && bus.we && at_data && cfg_on && idx_ok;
  assign lock_on = st_reg.cfg[IDX_CTL][CTL_LOCK_BIT] || hw_lock;

  // status word lives in the sticky flop, the rest in the main state
  always_comb begin
    cur = st_reg.cfg;
    cur[IDX_STS] = sticky_reg;
  end

  // hardware updates and lock masks per word
  always_comb begin
    hw_set = '0;
    hw_clr = '0;
    hw_set[IDX_ID] = ID_VALUE;
    hw_clr[IDX_ID] = ~ID_VALUE;
    hw_set[IDX_STS][STS_PME_LSB +: NPORT] = st_reg.pme_s2;
    hw_set[IDX_STS][STS_RO_LSB +: 8] = hw_status;
    hw_clr[IDX_STS][STS_RO_LSB +: 8] = ~hw_status;
    hw_clr[IDX_SET][7:0] = set_bits_clr;
    for (int i = 0; i < NREG; i++) begin
      locked[i] = st_reg.done[i] | (LOCK_MASK[i] & {32{lock_on}});
    end
  end

  // ************************************************************
  // attribute merge for the addressed word
  // ************************************************************
  cra_attr_merge u_merge (
    .cur      (cur[idx_ok ? idx : IDX_ID]),
    .wr_en    (cfg_wr),
    .be       (bus.be),
    .wdata    (bus.wdata),
    .rw_mask  (RW_MASK[idx_ok ? idx : IDX_ID]),
    .w1c_mask (W1C_MASK[idx_ok ? idx : IDX_ID]),
    .w1s_mask (W1S_MASK[idx_ok ? idx : IDX_ID]),
    .locked   (locked[idx_ok ? idx : IDX_ID]),
    .hw_set   (hw_set[idx_ok ? idx : IDX_ID]),
    .hw_clr   (hw_clr[idx_ok ? idx : IDX_ID]),
    .nxt      (merged)
  );

  // read mux: disabled or missing word reads all ones like an aborted cycle
  always_comb begin
    rd_word = ALL_ONES;
    if (at_ptr) begin
      rd_word = (bus.be == BE_DWORD) ? st_reg.ptr : 32'h0000_0000;
    end else if (at_data && cfg_on && idx_ok) begin
      rd_word = cur[idx] & ~WO_MASK[idx];
    end
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    st_next = st_reg;
    sticky_next = sticky_reg;
    // port requests are pins: two flops before any use
    st_next.pme_s1 = port_pme_req;
    st_next.pme_s2 = st_reg.pme_s1;
    // hardware updates for every word, addressed one replaced below
    for (int i = 0; i < NREG; i++) begin
      st_next.cfg[i] = (cur[i] & ~hw_clr[i]) | hw_set[i];
    end
    sticky_next = (sticky_reg & ~hw_clr[IDX_STS]) | hw_set[IDX_STS];
    st_next.cfg[IDX_STS] = 32'h0000_0000;
    st_next.ack = take;
    st_next.dbl_pulse = 1'b0;
    if (take) begin
      st_next.rdata = rd_word & cra_be_mask(bus.be);
    end
    // pointer takes only a full dword write, narrower ones drop
    if (take && bus.we && at_ptr && bus.be == BE_DWORD) begin
      st_next.ptr = bus.wdata & PTR_DEF;
    end
    if (cfg_wr) begin
      if (idx == IDX_STS) begin
        sticky_next = merged;
      end else begin
        st_next.cfg[idx] = merged;
      end
      st_next.done[idx] = st_reg.done[idx] | (cra_be_mask(bus.be) & ONCE_MASK[idx]);
      if (WO_MASK[idx] != 32'h0000_0000) begin
        st_next.dbl_pulse = 1'b1;
        st_next.dbl_data = bus.wdata & cra_be_mask(bus.be);
      end
    end
    // pin pulled low while an enabled port request is pending
    st_next.pme_drive = |(sticky_next[STS_PME_LSB +: NPORT]
                          & sticky_next[STS_ENA_LSB +: NPORT]);
  end

  // ************************************************************
  // registers
  // ************************************************************
  // soft reset spares the sticky status word
  always_ff @(posedge sys_clk or negedge rst_b or negedge soft_reset_in_n) begin
    if (!rst_b || !soft_reset_in_n) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // power reset alone clears the sticky word
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sticky_reg <= 32'h0000_0000;
    end else begin
      sticky_reg <= sticky_next;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign bus.ack        = st_reg.ack;
  assign bus.rdata      = st_reg.rdata;
  assign bus.pme_o      = 1'b0;             // open drain: only ever pulls low
  assign bus.pme_oe     = st_reg.pme_drive;
  assign doorbell_pulse = st_reg.dbl_pulse;
  assign doorbell_data  = st_reg.dbl_data;

endmodule : cra_dev

// ===== cra_host.sv
// cra_host: host end, pointer then data cycles with read-merge-write
`timescale 1ns/100ps
module cra_host (
  // clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst_b,
  // device side
  cra_if.host                             bus,
  // command port
  input  wire logic                       cmd_valid,
  output logic                            cmd_ready,
  input  wire logic                       cmd_write,
  input  wire logic [cra_pkg::IW-1:0]     cmd_index,
  input  wire logic [31:0]                cmd_wmask,
  input  wire logic [31:0]                cmd_wdata,
  // answer port
  output logic                            rsp_valid,
  output logic      [31:0]                rsp_data,
  output logic                            pme_seen
);
  import cra_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_PTR  = 2'b01,
    H_RD   = 2'b11,
    H_WR   = 2'b10
  } cra_hstate_t;

  typedef struct packed {
    cra_hstate_t   fsm;
    logic          we;
    logic [AW-1:0] addr;
    logic [31:0]   wdata;
    logic          wr_cmd;
    logic [IW-1:0] idx;
    logic [31:0]   umask;
    logic [31:0]   udata;
    logic          rsp_v;
    logic [31:0]   rsp_d;
    logic          pme_s1;
    logic          pme_s2;
  } cra_host_state_t;

  cra_host_state_t st_reg;
  cra_host_state_t st_next;
  logic [31:0]     keep;

  // reserved and untouched bits keep what was read; status ones never echo back
  assign keep = bus.rdata & ~W1C_MASK[st_reg.idx] & ~st_reg.umask;

  // ************************************************************
  // sequencer
  // ************************************************************
  always_comb begin
    st_next = st_reg;
    st_next.rsp_v = 1'b0;
    st_next.pme_s1 = ~bus.pm_event_request_n;
    st_next.pme_s2 = st_reg.pme_s1;
    case (st_reg.fsm)
      H_IDLE: begin
        if (cmd_valid) begin
          st_next.fsm = H_PTR;
          st_next.wr_cmd = cmd_write;
          st_next.idx = cmd_index;
          st_next.umask = cmd_wmask & DEF_MASK[cmd_index];
          st_next.udata = cmd_wdata;
          st_next.we = 1'b1;
          st_next.addr = PTR_IO;
          // pointer written straight, always a full dword
          st_next.wdata = 32'h8000_0000 | {24'h00_0000, cmd_index, 2'b00};
        end
      end
      H_PTR: begin
        if (bus.ack) begin
          st_next.fsm = H_RD;
          st_next.we = 1'b0;
          st_next.addr = DATA_IO;
        end
      end
      H_RD: begin
        if (bus.ack && st_reg.wr_cmd) begin
          st_next.fsm = H_WR;
          st_next.we = 1'b1;
          st_next.wdata = keep | (st_reg.udata & st_reg.umask);
        end else if (bus.ack) begin
          st_next.fsm = H_IDLE;
          st_next.rsp_v = 1'b1;
          st_next.rsp_d = bus.rdata & DEF_MASK[st_reg.idx];
        end
      end
      H_WR: begin
        if (bus.ack) begin
          st_next.fsm = H_IDLE;
          st_next.we = 1'b0;
          st_next.rsp_v = 1'b1;
          st_next.rsp_d = st_reg.wdata;
        end
      end
      default: begin
        st_next.fsm = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      st_reg <= '{fsm: H_IDLE, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign bus.req   = (st_reg.fsm != H_IDLE);
  assign bus.we    = st_reg.we;
  assign bus.addr  = st_reg.addr;
  assign bus.be    = BE_DWORD;
  assign bus.wdata = st_reg.wdata;
  assign cmd_ready = (st_reg.fsm == H_IDLE);
  assign rsp_valid = st_reg.rsp_v;
  assign rsp_data  = st_reg.rsp_d;
  assign pme_seen  = st_reg.pme_s2;

endmodule : cra_host

// ===== cra_properties.sv
// cra_properties: bus and event pin assertions beside the joined ends
`timescale 1ns/100ps
module cra_properties (
  // clock and reset
  input wire logic                   sys_clk,
  input wire logic                   rst_b,
  // host bus
  input wire logic                   req,
  input wire logic                   we,
  input wire logic [cra_pkg::AW-1:0] addr,
  input wire logic [3:0]             be,
  input wire logic [31:0]            wdata,
  input wire logic [31:0]            rdata,
  input wire logic                   ack,
  // event pin
  input wire logic                   pme_o,
  input wire logic                   pme_oe,
  input wire logic                   pm_event_request_n
);
  import cra_pkg::*;
  logic [31:0]   ptr_reg;
  logic [IW-1:0] idx;
  logic          vld;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // shadow of the pointer, so data reads are judged against the word picked
  always_ff @(posedge sys_clk) begin
    if (!rst_b) ptr_reg <= PTR_DEF;
    else if (req && !ack && we && addr == PTR_IO && be == BE_DWORD) ptr_reg <= wdata;
  end
  assign idx = ptr_reg[PTR_IDX_LSB +: IW];
  assign vld = ptr_reg[PTR_EN_BIT] && (idx < NREG);

  ack_pulse_a:   assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  ack_timing_a:  assert property (req && !ack |=> ack)
    else $error("request not answered next cycle");
  no_spur_a:     assert property (ack |-> $past(req) && !$past(ack))
    else $error("ack without a taken request");
  host_dword_a:  assert property (req |-> be == BE_DWORD)
    else $error("host used a partial access");
  ptr_direct_a:  assert property (req && addr == PTR_IO |-> we && wdata[PTR_EN_BIT])
    else $error("pointer not written directly");
  lane_mask_a:   assert property (ack && $past(!we) |->
                   (rdata & ~cra_be_mask($past(be))) == 32'h0000_0000)
    else $error("unaddressed lane returned data");
  rd_defined_a:  assert property (ack && $past(req && !we && addr == DATA_IO) && vld |->
                   (rdata & ~DEF_MASK[idx]) == 32'h0000_0000
                   && (idx != IDX_DBL || rdata == 32'h0000_0000))
    else $error("undefined or write-only bits read nonzero");
  hidden_one_a:  assert property (ack && $past(req && !we && addr == DATA_IO) && !vld |->
                   rdata == ALL_ONES)
    else $error("gated access did not read all ones");
  pme_pin_a:     assert property (pm_event_request_n == !pme_oe && (!pme_oe || !pme_o))
    else $error("event pin not open drain low");

  // main scenarios
  cover property (ack && $past(req && we && addr == DATA_IO));
  cover property (ack && $past(req && !we && addr == DATA_IO) && !vld);
  cover property ($rose(pme_oe));
endmodule : cra_properties

// ===== cfg_register_access_attrs_tb.sv
// cfg_register_access_attrs_tb: host and device ends joined, plus a device driven directly
`timescale 1ns/100ps
module cfg_register_access_attrs_tb;
  import cra_pkg::*;
  localparam logic [31:0] ID_VAL = 32'h0001_0001; // arbitrary identity word
  logic          sys_clk;
  logic          rst_b;
  logic          soft_reset_in_n;
  logic [3:0]    port_pme_req;
  logic [7:0]    hw_status;
  logic [7:0]    set_bits_clr;
  logic          hw_lock;
  logic          doorbell_pulse;
  logic [31:0]   doorbell_data;
  logic          cmd_valid;
  logic          cmd_ready;
  logic          cmd_write;
  logic [IW-1:0] cmd_index;
  logic [31:0]   cmd_wmask;
  logic [31:0]   cmd_wdata;
  logic          rsp_valid;
  logic [31:0]   rsp_data;
  logic          pme_seen;
  int            fail_count;
  int            checks_done;
  int            db_count;

  cra_if bus_a ();
  cra_if bus_b ();
  cra_dev #(.ID_VALUE(ID_VAL)) u_cra_dev (.sys_clk(sys_clk), .rst_b(rst_b),
    .soft_reset_in_n(soft_reset_in_n), .bus(bus_a), .port_pme_req(port_pme_req),
    .hw_status(hw_status), .set_bits_clr(set_bits_clr), .hw_lock(hw_lock),
    .doorbell_pulse(doorbell_pulse), .doorbell_data(doorbell_data));
  // second device lets the bench issue partial and wrong-width cycles
  cra_dev #(.ID_VALUE(ID_VAL)) u_cra_dev_b (.sys_clk(sys_clk), .rst_b(rst_b),
    .soft_reset_in_n(1'b1), .bus(bus_b), .port_pme_req(port_pme_req),
    .hw_status(hw_status), .set_bits_clr(set_bits_clr), .hw_lock(hw_lock),
    .doorbell_pulse(), .doorbell_data());
  cra_host u_cra_host (.sys_clk(sys_clk), .rst_b(rst_b), .bus(bus_a),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
    .cmd_index(cmd_index), .cmd_wmask(cmd_wmask), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .pme_seen(pme_seen));
  cra_properties u_cra_properties (.sys_clk(sys_clk), .rst_b(rst_b), .req(bus_a.req),
    .we(bus_a.we), .addr(bus_a.addr), .be(bus_a.be), .wdata(bus_a.wdata),
    .rdata(bus_a.rdata), .ack(bus_a.ack), .pme_o(bus_a.pme_o), .pme_oe(bus_a.pme_oe),
    .pm_event_request_n(bus_a.pm_event_request_n));

  // ************************************************************
  // clock, doorbell monitor, shared tasks
  // ************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (doorbell_pulse === 1'b1) db_count <= db_count + 1;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // one command through the host end; bounded wait for its answer
  task automatic cmd(input logic wr, input logic [IW-1:0] i, input logic [31:0] m,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_index <= i;
    cmd_wmask <= m;
    cmd_wdata <= d;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    #1;
    check("cmd_ready", cmd_ready, 1'b0);
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (rsp_valid !== 1'b1 && n < 20);
    check("rsp_valid", rsp_valid, 1'b1);
    check("cmd_ready", cmd_ready, 1'b1);
    q = rsp_data;
  endtask : cmd

  task automatic wr(input logic [IW-1:0] i, input logic [31:0] m, input logic [31:0] d);
    logic [31:0] q;
    cmd(1'b1, i, m, d, q);
  endtask : wr

  task automatic rd(input logic [IW-1:0] i, input logic [31:0] exp);
    logic [31:0] q;
    cmd(1'b0, i, 32'h0000_0000, 32'h0000_0000, q);
    check("rsp_data", q, exp);
  endtask : rd

  // direct bus cycle on the second device, held until ack is sampled
  task automatic io(input logic w, input logic [15:0] a, input logic [3:0] b,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge sys_clk);
    bus_b.req <= 1'b1;
    bus_b.we <= w;
    bus_b.addr <= a;
    bus_b.be <= b;
    bus_b.wdata <= d;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (bus_b.ack !== 1'b1 && n < 10);
    check("ack", bus_b.ack, 1'b1);
    q = bus_b.rdata;
    bus_b.req <= 1'b0;
  endtask : io

  task automatic io_rd(input logic [15:0] a, input logic [3:0] b, input logic [31:0] exp);
    logic [31:0] q;
    io(1'b0, a, b, 32'h0000_0000, q);
    check("rdata", q, exp);
  endtask : io_rd

  task automatic t_ro_lock;
    rd(IDX_ID, ID_VAL);
    wr(IDX_ID, ALL_ONES, 32'h0000_0000);
    rd(IDX_ID, ID_VAL);
    wr(IDX_CTL, 32'h0000_FFFF, 32'h0000_1234);
    hw_lock <= 1'b1;
    wr(IDX_CTL, 32'h0000_FFFF, 32'h0000_AB56);
    rd(IDX_CTL, 32'h0000_1256);
    hw_lock <= 1'b0;
    wr(IDX_CTL, 32'h0000_FF00, 32'h0000_AB00);
    rd(IDX_CTL, 32'h0000_AB56);
    wr(IDX_CTL, 32'h0001_0000, 32'h0001_0000);
    wr(IDX_CTL, 32'h0001_FF00, 32'h0000_0000);
    // the first full-dword write already froze the lock bit at zero
    rd(IDX_CTL, 32'h0000_0056);
  endtask : t_ro_lock

  task automatic t_clear_set;
    wr(IDX_STS, 32'hFF00_00F0, 32'h0000_00F0);
    rd(IDX_STS, 32'hA500_00F0);
    port_pme_req <= 4'b0100;
    repeat (6) @(posedge sys_clk);
    port_pme_req <= 4'b0000;
    repeat (4) @(posedge sys_clk);
    check("pm_event_request_n", bus_a.pm_event_request_n, 1'b0);
    check("pme_seen", pme_seen, 1'b1);
    wr(IDX_STS, 32'h0000_0001, 32'h0000_0001);
    rd(IDX_STS, 32'hA500_00F4);
    port_pme_req <= 4'b0010;
    repeat (5) @(posedge sys_clk);
    wr(IDX_STS, 32'h0000_0006, 32'h0000_0006);
    rd(IDX_STS, 32'hA500_00F2);
    port_pme_req <= 4'b0000;
    repeat (4) @(posedge sys_clk);
    wr(IDX_STS, 32'h0000_0002, 32'h0000_0002);
    rd(IDX_STS, 32'hA500_00F0);
    check("pm_event_request_n", bus_a.pm_event_request_n, 1'b1);
    wr(IDX_SET, 32'h0000_00FF, 32'h0000_0081);
    wr(IDX_SET, 32'h0000_00FF, 32'h0000_0000);
    rd(IDX_SET, 32'h0000_0081);
    set_bits_clr <= 8'h01;
    @(posedge sys_clk);
    set_bits_clr <= 8'h00;
    rd(IDX_SET, 32'h0000_0080);
  endtask : t_clear_set

  task automatic t_once_reset;
    wr(IDX_DBL, ALL_ONES, 32'hCAFE_F00D);
    check("db_count", db_count, 1);
    check("doorbell_data", doorbell_data, 32'hCAFE_F00D);
    wr(IDX_ONCE, ALL_ONES, 32'h1111_2222);
    wr(IDX_ONCE, ALL_ONES, 32'h3333_4444);
    rd(IDX_ONCE, 32'h1111_2222);
    soft_reset_in_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    soft_reset_in_n <= 1'b1;
    rd(IDX_CTL, 32'h0000_0000);
    rd(IDX_STS, 32'hA500_00F0);
    // fresh after reset: lock bit taken once, then guards bits 15:8
    wr(IDX_CTL, 32'h0001_FF00, 32'h0001_AB00);
    wr(IDX_CTL, 32'h0000_FF00, 32'h0000_0000);
    rd(IDX_CTL, 32'h0001_AB00);
    wr(IDX_ONCE, ALL_ONES, 32'h5555_6666);
    rd(IDX_ONCE, 32'h5555_6666);
  endtask : t_once_reset

  task automatic t_lanes;
    logic [31:0] q;
    io(1'b1, PTR_IO, BE_DWORD, 32'h8000_0004, q);
    io(1'b1, DATA_IO, BE_DWORD, 32'h0000_1234, q);
    io(1'b1, DATA_IO, 4'b0010, 32'hFFFF_56FF, q);
    io_rd(DATA_IO, BE_DWORD, 32'h0000_5634);
    io_rd(DATA_IO, 4'b0001, 32'h0000_0034);
    io_rd(DATA_IO, 4'b0010, 32'h0000_5600);
    io(1'b1, PTR_IO, 4'b0001, 32'h0000_0014, q);
    io_rd(PTR_IO, BE_DWORD, 32'h8000_0004);
    io_rd(PTR_IO, 4'b0011, 32'h0000_0000);
    io(1'b1, PTR_IO, BE_DWORD, 32'h8000_0018, q);
    io_rd(DATA_IO, BE_DWORD, ALL_ONES);
    io_rd(16'h0C08, BE_DWORD, ALL_ONES);
    // host read of a missing word, its all-ones answer judged by the checker
    cmd(1'b0, 6'h06, 32'h0000_0000, 32'h0000_0000, q);
  endtask : t_lanes

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  // main sequence, reset held four cycles
  initial begin
    fail_count = 0;
    checks_done = 0;
    db_count = 0;
    rst_b = 1'b0;
    soft_reset_in_n = 1'b1;
    port_pme_req = 4'b0000;
    hw_status = 8'hA5;
    set_bits_clr = 8'h00;
    hw_lock = 1'b0;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_index = '0;
    cmd_wmask = 32'h0000_0000;
    cmd_wdata = 32'h0000_0000;
    bus_b.req = 1'b0;
    bus_b.we = 1'b0;
    bus_b.addr = 16'h0000;
    bus_b.be = 4'h0;
    bus_b.wdata = 32'h0000_0000;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_ro_lock();
    t_clear_set();
    t_once_reset();
    t_lanes();
    finish_test();
  end

  // watchdog, well beyond the few hundred cycles the sequence needs
  initial begin
    repeat (5000) @(posedge sys_clk);
    fail_count++;
    finish_test();
  end
endmodule : cfg_register_access_attrs_tb
